// ### src/hifp_pkg.sv
package hifp_pkg;

  // Instruction store held by the controller
  localparam int HIFP_MEM_WORDS = 256;
  localparam int HIFP_IDX_W = 8;

  // Register bus geometry
  localparam int HIFP_AXI_AW = 8;
  localparam logic [1:0] HIFP_RESP_OKAY = 2'h0;
  localparam logic [1:0] HIFP_RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [7:0] HIFP_CTRL_OFF = 8'h00;
  localparam logic [7:0] HIFP_ABORT_BASE_OFF = 8'h04;
  localparam logic [7:0] HIFP_MEM_ADDR_OFF = 8'h08;
  localparam logic [7:0] HIFP_MEM_DATA_OFF = 8'h0C;
  localparam logic [7:0] HIFP_STATUS_OFF = 8'h10;
  localparam logic [7:0] HIFP_FETCH_CNT_OFF = 8'h14;

  // Control register fields
  localparam int HIFP_CTRL_ENDIAN_BIT = 0;
  localparam int HIFP_CTRL_ABORT_EN_BIT = 1;
  localparam int HIFP_CTRL_WAIT_LSB = 4;
  localparam int HIFP_WAIT_W = 4;

  // Status register fields
  localparam int HIFP_STAT_RSVD_BIT = 0;
  localparam int HIFP_STAT_STALL_BIT = 1;
  localparam int HIFP_STAT_COMP_BIT = 2;

  // Reset values
  localparam logic [31:0] HIFP_CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] HIFP_ABORT_BASE_RST = 32'h0000_0100;
  localparam logic [31:0] HIFP_ZERO32 = 32'h0000_0000;

  // Fetch service states
  typedef enum logic [0:0] {
    HIFP_SERVE,
    HIFP_WAIT
  } hifp_state_e;

  // One captured fetch request
  typedef struct packed {
    logic seq;
    logic compressed;
    logic [31:1] addr;
  } hifp_fetch_s;

endpackage

// ### src/hifp_fetch_ctrl.sv
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Operation
// - Memory: nonsequential multi-cycle, sequential single cycle
// - Low wait input stalls both interfaces
// - Wait input changes only in phase two
// - System may stretch clock phases instead
// - Controller latches address/control during wait states
// - Abort marked with data, taken at execute
// - Unused prefetch abort tied low
// - State output low word, high halfword
// - Word state: memory ignores address bit one
// - One endian setting governs both interfaces
module hifp_fetch_ctrl
  import hifp_pkg::*;
(
  input wire logic core_clk, // Core clock, shared with the device
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [HIFP_AXI_AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [HIFP_AXI_AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic fetch_request_n, // Device fetch request, active low
  input wire logic fetch_sequential, // Device sequential flag
  input wire logic [31:1] fetch_address, // Device halfword address
  input wire logic compressed_state_out, // Device halfword fetch state
  output logic [31:0] fetch_data_in, // Instruction data to device
  output logic prefetch_abort_in, // Abort mark with the data
  output logic stall_request_n, // Wait input of device, active low
  output logic endian_select // Endian setting for both interfaces
);

  // Word index into the store; bit one never takes part
  function automatic logic [HIFP_IDX_W-1:0] word_idx(input logic [31:1] a);
    word_idx = a[HIFP_IDX_W+1:2];
  endfunction

  // Byte-lane merge for strobed register writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge_bytes = m;
  endfunction

  logic [31:0] mem [HIFP_MEM_WORDS]; // Instruction store
  logic [31:0] ctrl_reg; // Endian, abort enable, wait count
  logic [31:0] abort_base_reg; // First aborting word index
  logic [HIFP_IDX_W-1:0] mem_addr_reg; // Software store pointer
  logic rsvd_seen_reg; // Sticky reserved cycle code seen
  logic [31:0] fetch_cnt_reg; // Delivered fetches
  hifp_state_e state_reg; // Fetch service state
  hifp_fetch_s lat_reg; // Latched request for waited fetch
  logic [HIFP_WAIT_W-1:0] wait_cnt_reg; // Remaining wait cycles
  logic [31:0] data_reg; // Fetch data output
  logic abort_reg; // Abort mark output
  logic stall_n_reg; // Wait output
  logic endian_reg; // Endian output
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg; // Bus responses
  logic [31:0] rdata_reg; // Bus read data
  logic aw_got, w_got; // Address and data held
  logic [7:0] aw_addr_lat; // Held write address
  logic [31:0] w_data_lat; // Held write data
  logic [3:0] w_strb_lat; // Held write strobes

  logic take; // Request accepted this edge
  logic rsvd_code; // Reserved request code on the pins
  logic deliver; // Data presented this edge
  hifp_fetch_s in_req; // Request as seen on the pins
  hifp_fetch_s src_req; // Request being answered
  logic src_abort; // Abort decision for it
  logic [HIFP_WAIT_W-1:0] wait_cfg; // Nonsequential wait states
  logic abort_en; // Abort marking enabled
  logic do_write; // Register write performed
  logic w1c_rsvd; // Software clears reserved flag

  // Requests are sampled only at edges closing an unstalled cycle,
  // since during a stall the device already shows its next request
  always_comb begin
    in_req.seq = fetch_sequential;
    in_req.compressed = compressed_state_out;
    in_req.addr = fetch_address;
    if (!compressed_state_out) begin
      in_req.addr[1] = 1'b0; // Word fetch: bit one is ignored
    end
    take = stall_n_reg && !fetch_request_n; // Cycle code decode
    rsvd_code = stall_n_reg && fetch_request_n && fetch_sequential;
    wait_cfg = ctrl_reg[HIFP_CTRL_WAIT_LSB +: HIFP_WAIT_W];
    abort_en = ctrl_reg[HIFP_CTRL_ABORT_EN_BIT];
    src_req = (state_reg == HIFP_WAIT) ? lat_reg : in_req;
    deliver = (state_reg == HIFP_WAIT) ? (wait_cnt_reg == 4'h0)
            : (take && (fetch_sequential || wait_cfg == 4'h0));
    src_abort = abort_en && ({2'b00, src_req.addr[31:2]} >= abort_base_reg);
  end

  // Fetch sequencing and wait-state insertion
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= HIFP_SERVE;
      wait_cnt_reg <= 4'h0;
      stall_n_reg <= 1'b1;
    end else begin
      case (state_reg)
        HIFP_SERVE: begin
          if (take && !fetch_sequential && wait_cfg != 4'h0) begin
            state_reg <= HIFP_WAIT; // Nonsequential: slow access
            wait_cnt_reg <= wait_cfg - 4'h1;
            stall_n_reg <= 1'b0; // Pin stall, clock never stretched
          end
        end
        HIFP_WAIT: begin
          if (wait_cnt_reg == 4'h0) begin
            state_reg <= HIFP_SERVE;
            stall_n_reg <= 1'b1; // Release after final wait cycle
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= HIFP_SERVE;
          stall_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // Hold the waited request; the pins already show the next one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lat_reg <= '0;
    end else if (take && state_reg == HIFP_SERVE) begin
      lat_reg <= in_req;
    end
  end

  // Data and abort mark; the full word is served and the device picks
  // its halfword lane from the endian setting and address bit one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      data_reg <= HIFP_ZERO32;
      abort_reg <= 1'b0;
    end else if (deliver) begin
      data_reg <= mem[word_idx(src_req.addr)];
      abort_reg <= src_abort; // Marked with the data
    end else begin
      abort_reg <= abort_reg && abort_en; // Off means held low
    end
  end

  // Fetch counter and sticky reserved-code flag; set beats clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fetch_cnt_reg <= HIFP_ZERO32;
      rsvd_seen_reg <= 1'b0;
    end else begin
      if (deliver) begin
        fetch_cnt_reg <= fetch_cnt_reg + 32'h0000_0001;
      end
      if (rsvd_code) begin
        rsvd_seen_reg <= 1'b1;
      end else if (w1c_rsvd) begin
        rsvd_seen_reg <= 1'b0;
      end
    end
  end

  // Write channel: address and data accepted in either order
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= HIFP_RESP_OKAY;
      aw_addr_lat <= 8'h00;
      w_data_lat <= HIFP_ZERO32;
      w_strb_lat <= 4'h0;
    end else begin
      if (!aw_got && !awready_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (s_axi_awvalid && awready_reg) begin
        aw_got <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_lat <= s_axi_awaddr;
      end
      if (!w_got && !wready_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_got <= 1'b1;
        wready_reg <= 1'b0;
        w_data_lat <= s_axi_wdata;
        w_strb_lat <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_lat > HIFP_FETCH_CNT_OFF || aw_addr_lat[1:0] != 2'h0)
                   ? HIFP_RESP_SLVERR : HIFP_RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign do_write = aw_got && w_got && !bvalid_reg;
  assign w1c_rsvd = do_write && aw_addr_lat == HIFP_STATUS_OFF
                  && w_strb_lat[0] && w_data_lat[HIFP_STAT_RSVD_BIT];

  // Software registers; the endian bit feeds both interfaces
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= HIFP_CTRL_RST;
      abort_base_reg <= HIFP_ABORT_BASE_RST;
      mem_addr_reg <= '0;
      endian_reg <= 1'b0;
    end else begin
      endian_reg <= ctrl_reg[HIFP_CTRL_ENDIAN_BIT];
      if (do_write) begin
        case (aw_addr_lat)
          HIFP_CTRL_OFF: ctrl_reg <= merge_bytes(ctrl_reg, w_data_lat, w_strb_lat);
          HIFP_ABORT_BASE_OFF: begin
            abort_base_reg <= merge_bytes(abort_base_reg, w_data_lat, w_strb_lat);
          end
          HIFP_MEM_ADDR_OFF: mem_addr_reg <= w_data_lat[HIFP_IDX_W-1:0];
          HIFP_MEM_DATA_OFF: mem_addr_reg <= mem_addr_reg + 8'h01; // Auto step
          default: begin
          end
        endcase
      end
    end
  end

  // Instruction store write port
  always_ff @(posedge core_clk) begin
    if (do_write && aw_addr_lat == HIFP_MEM_DATA_OFF) begin
      mem[mem_addr_reg] <= merge_bytes(mem[mem_addr_reg], w_data_lat, w_strb_lat);
    end
  end

  // Read channel: one read at a time, answered the next edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= HIFP_ZERO32;
      rresp_reg <= HIFP_RESP_OKAY;
    end else begin
      if (!arready_reg && !rvalid_reg) begin
        arready_reg <= 1'b1;
      end
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rresp_reg <= HIFP_RESP_OKAY;
        case (s_axi_araddr)
          HIFP_CTRL_OFF: rdata_reg <= ctrl_reg;
          HIFP_ABORT_BASE_OFF: rdata_reg <= abort_base_reg;
          HIFP_MEM_ADDR_OFF: rdata_reg <= {24'h00_0000, mem_addr_reg};
          HIFP_MEM_DATA_OFF: rdata_reg <= mem[mem_addr_reg];
          HIFP_STATUS_OFF: begin
            rdata_reg <= {29'h0000_0000, compressed_state_out, ~stall_n_reg,
                          rsvd_seen_reg};
          end
          HIFP_FETCH_CNT_OFF: rdata_reg <= fetch_cnt_reg;
          default: begin
            rdata_reg <= HIFP_ZERO32;
            rresp_reg <= HIFP_RESP_SLVERR; // Unmapped address
          end
        endcase
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Output pins, each straight from a flip-flop
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign fetch_data_in = data_reg;
  assign prefetch_abort_in = abort_reg;
  assign stall_request_n = stall_n_reg;
  assign endian_select = endian_reg;

  // Checks on the controller's own pin behaviour and its latched request
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  seq_single_cycle_a: assert property (
    (state_reg == HIFP_SERVE && take && fetch_sequential) |=> stall_request_n)
    else $error("sequential fetch was wait-stated");

  nseq_wait_stall_a: assert property (
    (state_reg == HIFP_SERVE && take && !fetch_sequential && wait_cfg != 4'h0)
      |=> !stall_request_n)
    else $error("nonsequential fetch not stalled");

  stall_release_a: assert property (
    $fell(stall_request_n) |-> ##[1:15] stall_request_n)
    else $error("stall held past wait count");

  wait_change_a: assert property (
    $rose(stall_request_n) |-> $past(deliver) && $past(wait_cnt_reg) == 4'h0)
    else $error("stall released early");

  latch_hold_a: assert property (
    (!stall_request_n && !$past(stall_request_n)) |-> $stable(lat_reg))
    else $error("latched request changed during wait");

  abort_with_data_a: assert property (
    deliver |=> prefetch_abort_in == $past(src_abort))
    else $error("abort mark not paired with data");

  abort_tied_low_a: assert property (
    $past(!abort_en) |-> !prefetch_abort_in)
    else $error("abort raised while disabled");

  word_bit_one_a: assert property (
    (state_reg == HIFP_SERVE && take && !compressed_state_out) |=> lat_reg.addr[1] == 1'b0)
    else $error("address bit one used in word state");

  endian_follow_a: assert property (
    $changed(endian_select) |-> $past(ctrl_reg[HIFP_CTRL_ENDIAN_BIT], 1) == endian_select)
    else $error("endian output not from control");

endmodule

// ### verification/hifp_core_model.sv
`timescale 1ns/10ps
// Behavioural fetch side of the processor core; the bench feeds it one cycle code per step
module hifp_core_model
  import hifp_pkg::*;
(
  input wire logic core_clk, // Core clock, the only timing source
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic stall_request_n, // Wait input, active low
  input wire logic [31:0] fetch_data_in, // Instruction data bus
  input wire logic prefetch_abort_in, // Abort mark with the data
  input wire logic endian_select, // Endian setting
  input wire logic next_req_n, // Next request from bench, active low
  input wire logic next_seq, // Next sequential flag from bench
  input wire logic [31:1] next_addr, // Next halfword address from bench
  input wire logic next_comp, // Next fetch state from bench
  output logic fetch_request_n, // Fetch request, active low
  output logic fetch_sequential, // Sequential flag
  output logic [31:1] fetch_address, // Halfword address
  output logic compressed_state_out, // High in halfword state
  output logic exported_internal_clock, // Stretched internal clock
  output logic got_valid, // One-cycle pulse per instruction taken
  output logic [31:0] got_instr, // Instruction as the core sees it
  output logic got_abort // Abort mark taken with it
);
  logic pend_reg; // A fetch was issued and awaits its data
  logic pend_a1_reg; // Address bit one of that fetch
  logic pend_comp_reg; // Fetch state of that fetch
  logic due_reg; // Its data stands on the bus this cycle
  logic due_a1_reg; // Address bit one of the fetch now served
  logic due_comp_reg; // Fetch state of the fetch now served

  // Internal clock only ticks while the wait input is high
  assign exported_internal_clock = core_clk | ~stall_request_n;

  // Every step of the core happens on an internal clock edge, so a stall freezes all but the got_valid pulse
  always_ff @(posedge core_clk) begin
    got_valid <= 1'b0;
    if (!rst_n) begin
      fetch_request_n <= 1'b1;
      fetch_sequential <= 1'b0;
      fetch_address <= '0;
      compressed_state_out <= 1'b0;
      pend_reg <= 1'b0;
      pend_a1_reg <= 1'b0;
      pend_comp_reg <= 1'b0;
      due_reg <= 1'b0;
      due_a1_reg <= 1'b0;
      due_comp_reg <= 1'b0;
      got_instr <= 32'h0000_0000;
      got_abort <= 1'b0;
    end else if (stall_request_n) begin // Held outputs while stalled
      // Next cycle code and address go out one cycle ahead of the data
      fetch_request_n <= next_req_n;
      fetch_sequential <= next_seq; // Code 1,1 only when the bench orders it
      fetch_address <= next_addr;
      compressed_state_out <= next_comp;
      pend_reg <= ~next_req_n;
      pend_a1_reg <= next_addr[1];
      pend_comp_reg <= next_comp;
      // Data is sampled one advancing cycle after the address phase, not at its end
      due_reg <= pend_reg;
      due_a1_reg <= pend_a1_reg;
      due_comp_reg <= pend_comp_reg;
      if (due_reg) begin // Instruction enters execute
        got_valid <= 1'b1;
        got_abort <= prefetch_abort_in;
        if (!due_comp_reg) begin
          got_instr <= fetch_data_in; // Whole word in word state
        end else if (due_a1_reg ^ endian_select) begin
          got_instr <= {16'h0000, fetch_data_in[31:16]}; // Upper lane
        end else begin
          got_instr <= {16'h0000, fetch_data_in[15:0]}; // Lower lane
        end
      end
    end
  end
endmodule

// ### verification/harvard_instruction_fetch_port_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module harvard_instruction_fetch_port_tb_top
  import hifp_pkg::*;
;
  typedef struct packed {
    logic req_n; // Request code
    logic seq; // Sequential flag
    logic comp; // Halfword state
    logic [31:0] addr; // Byte address
    logic [31:0] instr; // Instruction the core should see
    logic abort; // Abort mark the core should see
  } hifp_row_s;
  logic core_clk, rst_n; // Clock and reset
  logic [7:0] s_axi_awaddr, s_axi_araddr; // Register addresses
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // Write handshakes
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // Response and read
  logic s_axi_rvalid, s_axi_rready; // Read data handshake
  logic [31:0] s_axi_wdata, s_axi_rdata, fetch_data_in, got_instr; // Data words
  logic [3:0] s_axi_wstrb; // Byte strobes, always full words
  logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
  logic fetch_request_n, fetch_sequential, compressed_state_out; // Core fetch outputs
  logic [31:1] fetch_address, next_addr; // Halfword addresses
  logic prefetch_abort_in, stall_request_n, endian_select; // Controller outputs
  logic next_req_n, next_seq, next_comp, got_valid, got_abort; // Model steering
  int mismatches = 0; // Failed comparisons
  int total_checks = 0; // All comparisons
  int cur_wait = 0; // Wait states now programmed
  int stall_cnt = 0; // Length of the current stall
  logic [32:0] exp_q[$]; // Instructions still owed to the core
  logic [32:0] exp_item; // Popped expectation
  // Store contents; halfword lanes differ so a wrong lane shows
  logic [31:0] words [4] = '{32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888};
  // Per phase: control word (endian, abort enable, wait states) and first row
  logic [31:0] ctrls [3] = '{32'h0000_0012, 32'h0000_00F1, 32'h0000_0002};
  int first [4] = '{0, 8, 11, 13};
  hifp_row_s rows [13] = '{
    '{1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h1111_2222, 1'b0},
    '{1'b0, 1'b1, 1'b0, 32'h0000_0004, 32'h3333_4444, 1'b0},
    '{1'b1, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, 1'b1, 1'b1, 32'h0000_0008, 32'h0000_6666, 1'b0},
    '{1'b0, 1'b1, 1'b1, 32'h0000_000A, 32'h0000_5555, 1'b0},
    '{1'b0, 1'b1, 1'b0, 32'h0000_000C, 32'h7777_8888, 1'b1},
    '{1'b0, 1'b0, 1'b0, 32'h0000_0006, 32'h3333_4444, 1'b0},
    '{1'b1, 1'b1, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, 1'b0, 1'b1, 32'h0000_0008, 32'h0000_5555, 1'b0},
    '{1'b0, 1'b1, 1'b1, 32'h0000_000A, 32'h0000_6666, 1'b0},
    '{1'b0, 1'b1, 1'b0, 32'h0000_000C, 32'h7777_8888, 1'b0},
    '{1'b0, 1'b0, 1'b0, 32'h0000_000C, 32'h7777_8888, 1'b1},
    '{1'b0, 1'b1, 1'b0, 32'h0000_0000, 32'h1111_2222, 1'b0}};

  hifp_fetch_ctrl dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_request_n, .fetch_sequential,
    .fetch_address, .compressed_state_out, .fetch_data_in, .prefetch_abort_in,
    .stall_request_n, .endian_select);
  hifp_core_model core (.core_clk, .rst_n, .stall_request_n, .fetch_data_in,
    .prefetch_abort_in, .endian_select, .next_req_n, .next_seq, .next_addr, .next_comp,
    .fetch_request_n, .fetch_sequential, .fetch_address, .compressed_state_out,
    .exported_internal_clock(), .got_valid, .got_instr, .got_abort);

  // Free-running core clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, aw_hs, w_hs;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Readies are looked at mid-cycle; the handshake is the following rising edge
    while (!(aw_ok && w_ok)) begin
      @(negedge core_clk);
      aw_hs = !aw_ok && s_axi_awready === 1'b1;
      w_hs = !w_ok && s_axi_wready === 1'b1;
      @(posedge core_clk);
      if (aw_hs) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (w_hs) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge core_clk); while (s_axi_arready !== 1'b1);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    `CHK("write response", HIFP_RESP_OKAY, r)
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    `CHK(nm, e, d)
    `CHK("read response", er, r)
  endtask

  // Every instruction the core takes is matched against the owed list
  // Looked at mid-cycle, where the model's outputs are settled
  always @(negedge core_clk) begin
    if (got_valid === 1'b1) begin
      `CHK("capture owed", 1'b1, exp_q.size() != 0)
      exp_item = exp_q.pop_front();
      `CHK("instruction", exp_item[32:1], got_instr)
      `CHK("abort mark", exp_item[0], got_abort)
    end
  end

  // Stall length must equal the programmed wait states, however long
  always @(negedge core_clk) begin
    if (rst_n === 1'b1 && stall_request_n === 1'b0) begin
      stall_cnt++;
    end else if (stall_cnt != 0) begin
      `CHK("stall length", cur_wait, stall_cnt)
      stall_cnt = 0;
    end
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end

  initial begin
    logic [1:0] resp;
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {next_req_n, next_seq, next_comp, next_addr} = {1'b1, 33'h0_0000_0000};
    repeat (3) @(posedge core_clk);
    `CHK("stall in reset", 1'b1, stall_request_n)
    `CHK("data in reset", 32'h0000_0000, fetch_data_in)
    rst_n <= 1'b1;
    rd_chk("ctrl reset", HIFP_CTRL_OFF, HIFP_CTRL_RST, HIFP_RESP_OKAY);
    rd_chk("abort base reset", HIFP_ABORT_BASE_OFF, HIFP_ABORT_BASE_RST, HIFP_RESP_OKAY);
    rd_chk("unmapped read", 8'h18, HIFP_ZERO32, HIFP_RESP_SLVERR);
    axi_write(8'h1C, 32'hFFFF_FFFF, resp);
    `CHK("unmapped write", HIFP_RESP_SLVERR, resp)
    $display("test reset and map done");
    wr(HIFP_MEM_ADDR_OFF, HIFP_ZERO32);
    for (int k = 0; k < 4; k++) wr(HIFP_MEM_DATA_OFF, words[k]);
    wr(HIFP_MEM_ADDR_OFF, 32'h0000_0002);
    rd_chk("store word", HIFP_MEM_DATA_OFF, words[2], HIFP_RESP_OKAY);
    wr(HIFP_ABORT_BASE_OFF, 32'h0000_0003);
    for (int p = 0; p < 3; p++) begin
      wr(HIFP_CTRL_OFF, ctrls[p]);
      cur_wait = int'(ctrls[p][7:4]);
      repeat (2) @(posedge core_clk);
      `CHK("endian", ctrls[p][0], endian_select)
      for (int i = first[p]; i < first[p + 1]; i++) begin
        next_req_n <= rows[i].req_n;
        next_seq <= rows[i].seq;
        next_comp <= rows[i].comp;
        next_addr <= rows[i].addr[31:1];
        if (!rows[i].req_n) exp_q.push_back({rows[i].instr, rows[i].abort});
        // The model takes a row at the edge that ends a cycle with the stall off
        do @(negedge core_clk); while (stall_request_n !== 1'b1);
        @(posedge core_clk);
      end
      next_req_n <= 1'b1;
      next_seq <= 1'b0;
      next_comp <= 1'b0;
      while (exp_q.size() != 0) @(posedge core_clk);
      $display("test phase %0d done", p);
    end
    rd_chk("fetch count", HIFP_FETCH_CNT_OFF, 32'h0000_000B, HIFP_RESP_OKAY);
    rd_chk("status", HIFP_STATUS_OFF, 32'h0000_0001, HIFP_RESP_OKAY);
    wr(HIFP_STATUS_OFF, 32'h0000_0001);
    rd_chk("status cleared", HIFP_STATUS_OFF, HIFP_ZERO32, HIFP_RESP_OKAY);
    $display("test status done");
    // Second reset in mid-run: registers and counter return to their reset values
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK("stall in second reset", 1'b1, stall_request_n)
    rst_n <= 1'b1;
    rd_chk("ctrl after reset", HIFP_CTRL_OFF, HIFP_CTRL_RST, HIFP_RESP_OKAY);
    rd_chk("count after reset", HIFP_FETCH_CNT_OFF, HIFP_ZERO32, HIFP_RESP_OKAY);
    $display("test second reset done");
    stop_test();
  end
endmodule
